// ---- hdl/vmcs_top.sv ----
// Top of the video and memory clock synthesis block with its APB register file.
// Function
// RL1 - Three synthesizers: memory clock, primary pixel clock, secondary pixel clock.
// RL2 - Single refresh displays run from the primary pixel clock.
// RL3 - Dual refresh: primary drives panel, secondary drives CRT or slows blocks.
// RL4 - Derive write FIFO, read FIFO, memory, capture, engine, processor clocks.
// RL5 - TV clock from base reference for NTSC, PAL reference input for PAL.
// RL6 - Pixel numerator in one register, denominator and scaler in the next.
// RL7 - Pixel clock is reference times numerator over denominator over one plus scaler.
// RL8 - Enabled post scaler halves the output frequency.
// RL9 - Secondary clock is reference times its own numerator over denominator.
// RL10 - Memory clock is reference times memory numerator over memory denominator.
// RL11 - Standard modes use built-in pairs chosen by select and misc bits.
// RL12 - Software uses the recommended divider pairs for standard rates.
// RL13 - Panel config bit 7 enters dual refresh with a panel refresh clock.
// RL14 - Switching pixel settings never emits runt pulses or glitches.
//
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module vmcs_top import vmcs_pkg::*; (
  input  wire logic        pclk,                  // 200 MHz system clock.
  input  wire logic        presetn,               // Asynchronous reset, active low.
  input  wire logic [11:0] paddr,                 // APB byte address.
  input  wire logic        psel,                  // APB select.
  input  wire logic        penable,               // APB access phase.
  input  wire logic        pwrite,                // APB write.
  input  wire logic [31:0] pwdata,                // APB write data.
  output logic      [31:0] prdata,                // APB read data.
  output logic             pready,                // APB ready.
  output logic             pslverr,               // APB error.
  input  wire logic        ref_clock_in,          // Base reference level.
  input  wire logic        pal_reference_input,   // PAL reference level.
  output logic             memory_clock,          // Memory synthesizer clock.
  output logic             primary_pixel_clock,   // Primary pixel clock.
  output logic             secondary_pixel_clock, // Secondary pixel clock.
  output logic             panel_refresh_clock,   // Panel timing clock.
  output logic             crt_pixel_clock,       // CRT interface clock.
  output logic             write_fifo_clock,      // Write FIFO clock.
  output logic             read_fifo_clock,       // Read FIFO clock.
  output logic             memory_array_clock,    // Memory array clock.
  output logic             capture_clock,         // Video capture clock.
  output logic             drawing_engine_clock,  // Drawing engine clock.
  output logic             video_processor_clock, // Video processor clock.
  output logic             tv_encoder_clock,      // TV encoder clock.
  output logic             dual_refresh           // Dual refresh active.
);
  typedef struct packed {
    logic [7:0]             pix_num;
    logic [7:0]             pix_den;
    logic [7:0]             sec_num;
    logic [7:0]             sec_den;
    logic [7:0]             mem_num;
    logic [7:0]             mem_den;
    logic [7:0]             pix_sel;
    logic [7:0]             panel_cfg;
    logic [7:0]             misc_out;
    logic [16:0]            block_clk;
    logic                   ref_q;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   mem_clk;
    logic                   pri_clk;
    logic                   sec_clk;
    logic                   panel_clk;
    logic                   crt_clk;
    logic [NUM_DERIVED-1:0] derived;
    logic                   tv_clk;
  } vmcs_top_s;

  vmcs_top_s     s;
  vmcs_top_s     next_s;
  vmcs_setting_s builtin;
  logic          ref_tick;
  logic          mem_raw;
  logic          sec_raw;
  logic          fixed_raw;
  logic          prog_raw;
  logic          pri_raw;
  logic          crt_raw;
  logic          prog_active;
  logic          crt_on_sec;
  logic [32:0]   rd;
  logic [7:0]    wr_idx;
  logic          wr_go;

  // Read decode shared by data and error paths; bit 32 marks a mapped address.
  function automatic logic [32:0] reg_read(input vmcs_top_s r, input logic [11:0] a,
                                           input logic [3:0] st);
    logic [32:0] v;
    v = 33'h000000000;
    if (a[1:0] == 2'b00 && a[11:10] == 2'b00) begin
      case (a[9:2])
        IDX_PANEL_CFG: v = {1'b1, 24'h000000, r.panel_cfg};
        IDX_PIX_SEL:   v = {1'b1, 24'h000000, r.pix_sel};
        IDX_MEM_NUM:   v = {1'b1, 24'h000000, r.mem_num};
        IDX_MEM_DEN:   v = {1'b1, 24'h000000, r.mem_den};
        IDX_PIX_NUM:   v = {1'b1, 24'h000000, r.pix_num};
        IDX_PIX_DEN:   v = {1'b1, 24'h000000, r.pix_den};
        IDX_SEC_NUM:   v = {1'b1, 24'h000000, r.sec_num};
        IDX_SEC_DEN:   v = {1'b1, 24'h000000, r.sec_den};
        IDX_MISC_OUT:  v = {1'b1, 24'h000000, r.misc_out};
        IDX_BLOCK_CLK: v = {1'b1, 15'h0000, r.block_clk};
        IDX_STATUS:    v = {1'b1, 28'h0000000, st};
        default:       v = 33'h000000000;
      endcase
    end
    return v;
  endfunction : reg_read

  // RL11 built-in pair lookup
  assign builtin = vmcs_builtin(s.pix_sel[SEL_HI:SEL_LO], s.misc_out[MISC_SEL_HI:MISC_SEL_LO]);

  // The reference pin is synchronous to pclk, so a rising edge is a plain compare.
  assign ref_tick = ref_clock_in && !s.ref_q;

  // RL10 memory clock ratio
  vmcs_synth u_mem_synth (
    .pclk        (pclk),
    .presetn     (presetn),
    .ref_tick    (ref_tick),
    .numerator   (s.mem_num),
    .denominator (s.mem_den),
    .post_scale  (1'b0),
    .clk_out     (mem_raw)
  );

  // RL6 programmed numerator, denominator and scaler
  // RL7 programmed pixel ratio
  vmcs_synth u_prog_synth (
    .pclk        (pclk),
    .presetn     (presetn),
    .ref_tick    (ref_tick),
    .numerator   (s.pix_num),
    .denominator ({1'b0, s.pix_den[PS_BIT-1:0]}),
    .post_scale  (s.pix_den[PS_BIT]),
    .clk_out     (prog_raw)
  );

  // RL11 fixed standard-mode ratio
  vmcs_synth u_fixed_synth (
    .pclk        (pclk),
    .presetn     (presetn),
    .ref_tick    (ref_tick),
    .numerator   (builtin.num),
    .denominator (builtin.den),
    .post_scale  (builtin.ps),
    .clk_out     (fixed_raw)
  );

  // RL9 secondary ratio without scaler
  vmcs_synth u_sec_synth (
    .pclk        (pclk),
    .presetn     (presetn),
    .ref_tick    (ref_tick),
    .numerator   (s.sec_num),
    .denominator (s.sec_den),
    .post_scale  (1'b0),
    .clk_out     (sec_raw)
  );

  // RL14 clean change between built-in and programmed
  vmcs_clk_switch u_pix_switch (
    .pclk    (pclk),
    .presetn (presetn),
    .sel     (builtin.prog),
    .clk_a   (fixed_raw),
    .clk_b   (prog_raw),
    .clk_out (pri_raw),
    .on_b    (prog_active)
  );

  // RL3 CRT moves to the secondary clock
  vmcs_clk_switch u_crt_switch (
    .pclk    (pclk),
    .presetn (presetn),
    .sel     (s.panel_cfg[DUAL_BIT]),
    .clk_a   (pri_raw),
    .clk_b   (sec_raw),
    .clk_out (crt_raw),
    .on_b    (crt_on_sec)
  );

  assign wr_idx = paddr[9:2];
  assign wr_go = psel && penable && s.pready && pwrite && paddr[1:0] == 2'b00
                 && paddr[11:10] == 2'b00;

  always_comb begin
    next_s = s;
    rd = reg_read(s, paddr, {crt_on_sec, pri_raw, s.panel_cfg[DUAL_BIT], prog_active});
    next_s.ref_q = ref_clock_in;
    // Zero wait states: ready is raised for the access phase of every transfer.
    next_s.pready = psel && !penable;
    next_s.pslverr = 1'b0;
    next_s.prdata = 32'h00000000;
    if (psel && !penable) begin
      next_s.pslverr = !rd[32];
      if (!pwrite) begin
        next_s.prdata = rd[31:0];
      end
    end
    if (wr_go) begin
      case (wr_idx)
        IDX_PANEL_CFG: next_s.panel_cfg = pwdata[7:0];
        IDX_PIX_SEL:   next_s.pix_sel = pwdata[7:0];
        IDX_MEM_NUM:   next_s.mem_num = pwdata[7:0];
        IDX_MEM_DEN:   next_s.mem_den = pwdata[7:0];
        IDX_PIX_NUM:   next_s.pix_num = pwdata[7:0];
        IDX_PIX_DEN:   next_s.pix_den = pwdata[7:0];
        IDX_SEC_NUM:   next_s.sec_num = pwdata[7:0];
        IDX_SEC_DEN:   next_s.sec_den = pwdata[7:0];
        IDX_MISC_OUT:  next_s.misc_out = pwdata[7:0];
        IDX_BLOCK_CLK: next_s.block_clk = pwdata[16:0];
        default:       next_s.block_clk = s.block_clk;
      endcase
    end
    // RL1 three synthesized clocks
    next_s.mem_clk = mem_raw;
    next_s.pri_clk = pri_raw;
    next_s.sec_clk = sec_raw;
    // RL2 panel shares primary
    // RL13 panel refresh clock stays primary
    next_s.panel_clk = pri_raw;
    next_s.crt_clk = crt_raw;
    // RL4 per-block gated clocks
    for (int i = 0; i < NUM_DERIVED; i++) begin
      next_s.derived[i] = s.block_clk[i]
                          && (s.block_clk[BLK_SRC_LO + i] ? sec_raw : mem_raw);
    end
    // RL5 NTSC or PAL source
    next_s.tv_clk = s.block_clk[BLK_PAL_BIT] ? pal_reference_input : ref_clock_in;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{pix_num: RST_ZERO, pix_den: RST_ZERO, sec_num: RST_ZERO, sec_den: RST_ZERO,
             mem_num: RST_MEM_NUM, mem_den: RST_MEM_DEN, pix_sel: RST_ZERO,
             panel_cfg: RST_ZERO, misc_out: RST_ZERO, block_clk: RST_BLOCK_CLK,
             default: '0};
    end else begin
      s <= next_s;
    end
  end

  assign prdata                = s.prdata;
  assign pready                = s.pready;
  assign pslverr               = s.pslverr;
  assign memory_clock          = s.mem_clk;
  assign primary_pixel_clock   = s.pri_clk;
  assign secondary_pixel_clock = s.sec_clk;
  assign panel_refresh_clock   = s.panel_clk;
  assign crt_pixel_clock       = s.crt_clk;
  assign write_fifo_clock      = s.derived[0];
  assign read_fifo_clock       = s.derived[1];
  assign memory_array_clock    = s.derived[2];
  assign capture_clock         = s.derived[3];
  assign drawing_engine_clock  = s.derived[4];
  assign video_processor_clock = s.derived[5];
  assign tv_encoder_clock      = s.tv_clk;
  assign dual_refresh          = s.panel_cfg[DUAL_BIT];

  sequence seq_setup;
    psel && !penable;
  endsequence

  sequence seq_write_pix_num;
    psel && !penable && pwrite && paddr == {2'b00, IDX_PIX_NUM, 2'b00} ##1 psel && penable;
  endsequence

  sequence seq_write_panel_cfg;
    psel && !penable && pwrite && paddr == {2'b00, IDX_PANEL_CFG, 2'b00} ##1 psel && penable;
  endsequence

  // RL6 ready timing
  a_apb_ready_next: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    seq_setup |=> pready ##1 !pready)
    else $error("ready not one access cycle");

  // RL6 write lands
  a_pix_num_write: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    seq_write_pix_num |=> s.pix_num == $past(pwdata[7:0]))
    else $error("pixel numerator write lost");

  // RL6 read data
  a_pix_den_read: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    seq_setup and !pwrite && paddr == {2'b00, IDX_PIX_DEN, 2'b00}
    |=> prdata == {24'h000000, $past(s.pix_den)})
    else $error("pixel denominator read wrong");

  // RL6 idle bus quiet
  a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    !psel |=> !pready)
    else $error("ready without select");

  // RL6 idle data zero
  a_prdata_idle: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    !psel |=> prdata == 32'h00000000)
    else $error("read data without select");

  // RL6 mapped accepted
  a_mapped_no_err: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    seq_setup and paddr == {2'b00, IDX_MEM_NUM, 2'b00} |=> pready && !pslverr)
    else $error("mapped access refused");

  // RL6 unaligned refused
  a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn) // RL6
    seq_setup and paddr[1:0] != 2'b00 |=> pslverr && pready)
    else $error("unaligned access not refused");

  // RL13 panel follows primary
  a_panel_primary: assert property (@(posedge pclk) disable iff (!presetn) // RL13
    panel_refresh_clock == $past(pri_raw))
    else $error("panel clock differs from primary");

  // RL13 dual bit taken
  a_dual_enter: assert property (@(posedge pclk) disable iff (!presetn) // RL13
    seq_write_panel_cfg |=> dual_refresh == $past(pwdata[DUAL_BIT]))
    else $error("dual refresh bit not taken");

  // RL5 PAL source
  a_tv_pal_path: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    s.block_clk[BLK_PAL_BIT] && $past(s.block_clk[BLK_PAL_BIT])
    |-> tv_encoder_clock == $past(pal_reference_input))
    else $error("tv clock not from PAL input");

  // RL5 NTSC source
  a_tv_ntsc_path: assert property (@(posedge pclk) disable iff (!presetn) // RL5
    $past(presetn) && !$past(s.block_clk[BLK_PAL_BIT])
    |-> tv_encoder_clock == $past(ref_clock_in))
    else $error("tv clock not from base reference");

  // RL4 gated clock low
  a_gate_off_low: assert property (@(posedge pclk) disable iff (!presetn) // RL4
    !s.block_clk[0] && $past(!s.block_clk[0]) |-> !write_fifo_clock)
    else $error("gated write fifo clock toggles");

  // RL4 derived source
  a_derived_source: assert property (@(posedge pclk) disable iff (!presetn) // RL4
    $past(s.block_clk[3]) && $past(s.block_clk[BLK_SRC_LO + 3])
    |-> capture_clock == $past(sec_raw))
    else $error("capture clock not from secondary");

  // RL2 CRT on primary
  a_single_crt_primary: assert property (@(posedge pclk) disable iff (!presetn) // RL2
    !crt_on_sec && $past(!crt_on_sec) && $past(!crt_on_sec, 2) && $rose(crt_pixel_clock)
    |-> $past(pri_raw, 2))
    else $error("crt clock not from primary");

  // RL3 CRT on secondary
  a_dual_crt_sec: assert property (@(posedge pclk) disable iff (!presetn) // RL3
    crt_on_sec && $past(crt_on_sec) && $past(crt_on_sec, 2) && $rose(crt_pixel_clock)
    |-> $past(sec_raw, 2))
    else $error("crt clock not from secondary");
endmodule : vmcs_top

// ---- common/vmcs_pkg.sv ----
// Shared constants, types and lookup for the video and memory clock synthesis block.
package vmcs_pkg;
  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_PANEL_CFG = 8'h31;
  localparam logic [7:0] IDX_PIX_SEL   = 8'h68;
  localparam logic [7:0] IDX_MEM_NUM   = 8'h6a;
  localparam logic [7:0] IDX_MEM_DEN   = 8'h6b;
  localparam logic [7:0] IDX_PIX_NUM   = 8'h6c;
  localparam logic [7:0] IDX_PIX_DEN   = 8'h6d;
  localparam logic [7:0] IDX_SEC_NUM   = 8'h6e;
  localparam logic [7:0] IDX_SEC_DEN   = 8'h6f;
  localparam logic [7:0] IDX_MISC_OUT  = 8'h80;
  localparam logic [7:0] IDX_BLOCK_CLK = 8'h81;
  localparam logic [7:0] IDX_STATUS    = 8'h82;
  // Field positions.
  localparam int PS_BIT       = 7;
  localparam int SEL_HI       = 7;
  localparam int SEL_LO       = 5;
  localparam int MISC_SEL_HI  = 3;
  localparam int MISC_SEL_LO  = 2;
  localparam int DUAL_BIT     = 7;
  localparam int BLK_SRC_LO   = 8;
  localparam int BLK_PAL_BIT  = 16;
  localparam int NUM_DERIVED  = 6;
  // Values after reset.
  localparam logic [7:0]  RST_MEM_NUM   = 8'h20;
  localparam logic [7:0]  RST_MEM_DEN   = 8'h08;
  localparam logic [7:0]  RST_ZERO      = 8'h00;
  localparam logic [16:0] RST_BLOCK_CLK = 17'h0003f;
  // Built-in divider pairs for standard modes.
  localparam logic [7:0] BI_25_NUM = 8'h33;
  localparam logic [7:0] BI_25_DEN = 8'h1d;
  localparam logic [7:0] BI_28_NUM = 8'h5b;
  localparam logic [7:0] BI_28_DEN = 8'h17;
  localparam logic [7:0] BI_31_NUM = 8'h2c;
  localparam logic [7:0] BI_31_DEN = 8'h14;
  localparam logic [7:0] BI_35_NUM = 8'h39;
  localparam logic [7:0] BI_35_DEN = 8'h17;
  localparam logic [7:0] BI_49_NUM = 8'h53;
  localparam logic [7:0] BI_49_DEN = 8'h18;
  localparam logic [7:0] BI_78_NUM = 8'h6e;
  localparam logic [7:0] BI_78_DEN = 8'h14;
  localparam logic [7:0] BI_REF    = 8'h01;

  typedef enum logic [2:0] {
    VMCS_ON_A = 3'b001,
    VMCS_HOLD = 3'b010,
    VMCS_ON_B = 3'b100
  } vmcs_sw_e;

  typedef struct packed {
    logic       prog;
    logic       ps;
    logic [7:0] num;
    logic [7:0] den;
  } vmcs_setting_s;

  function automatic vmcs_setting_s vmcs_builtin(input logic [2:0] sel, input logic [1:0] cs);
    vmcs_setting_s r;
    r = '{prog: 1'b0, ps: 1'b0, num: BI_REF, den: BI_REF};
    if (sel[2:1] == 2'b11) begin
      r.num = BI_REF;
    end else if (sel[2:1] == 2'b01) begin
      r.num = sel[0] ? BI_78_NUM : BI_49_NUM;
      r.den = sel[0] ? BI_78_DEN : BI_49_DEN;
    end else if (sel[2:1] == 2'b00 && !cs[1]) begin
      case ({sel[0], cs[0]})
        2'b00:   begin r.num = BI_25_NUM; r.den = BI_25_DEN; end
        2'b01:   begin r.num = BI_28_NUM; r.den = BI_28_DEN; r.ps = 1'b1; end
        2'b10:   begin r.num = BI_31_NUM; r.den = BI_31_DEN; end
        default: begin r.num = BI_35_NUM; r.den = BI_35_DEN; end
      endcase
    end else begin
      r.prog = 1'b1;
    end
    return r;
  endfunction : vmcs_builtin
endpackage : vmcs_pkg

// ---- hdl/vmcs_synth.sv ----
// Ratio synthesizer: reference times numerator over denominator, optional halving.
`timescale 1ns/1ps
module vmcs_synth import vmcs_pkg::*; (
  input  wire logic       pclk,        // System clock.
  input  wire logic       presetn,     // Asynchronous reset, active low.
  input  wire logic       ref_tick,    // One pulse per reference period.
  input  wire logic [7:0] numerator,   // Ratio numerator.
  input  wire logic [7:0] denominator, // Ratio denominator; zero stops the clock.
  input  wire logic       post_scale,  // Halve the output.
  output logic            clk_out      // Synthesized clock level.
);
  typedef struct packed {
    logic [11:0] acc;
    logic        half;
    logic        clk;
  } vmcs_syn_s;
  vmcs_syn_s s, next_s;
  logic      fire;
  // Each reference period adds two numerator units, one per output half cycle.
  always_comb begin
    next_s = s;
    fire = (denominator != 8'h00) && (s.acc >= {4'h0, denominator});
    if (ref_tick && s.acc < 12'h800) begin
      next_s.acc = s.acc + {3'h0, numerator, 1'b0};
    end
    if (fire) begin
      next_s.acc = next_s.acc - {4'h0, denominator};
      // RL8 post scaler halving
      next_s.half = post_scale ? ~s.half : 1'b0;
      if (!post_scale || s.half) begin
        next_s.clk = ~s.clk;
      end
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign clk_out = s.clk;
  a_stopped_holds: assert property (@(posedge pclk) disable iff (!presetn) // RL7
    denominator == 8'h00 && $past(denominator) == 8'h00 |-> $stable(clk_out))
    else $error("synth clock moved with zero denominator");
  a_scaled_skip: assert property (@(posedge pclk) disable iff (!presetn) // RL8
    fire && post_scale && !s.half |=> $stable(clk_out))
    else $error("post scaler did not skip a toggle");
endmodule : vmcs_synth

// ---- hdl/vmcs_clk_switch.sv ----
// Glitch-free two-input clock selector, leaving the old side only while it is low and joining the new side only while it is low.
`timescale 1ns/1ps
module vmcs_clk_switch import vmcs_pkg::*; (
  input  wire logic pclk,    // System clock.
  input  wire logic presetn, // Asynchronous reset, active low.
  input  wire logic sel,     // High selects clk_b.
  input  wire logic clk_a,   // Source when sel is low.
  input  wire logic clk_b,   // Source when sel is high.
  output logic      clk_out, // Selected clock.
  output logic      on_b     // High while clk_b is passed.
);
  typedef struct packed {
    vmcs_sw_e state;
    logic     out;
  } vmcs_sws_s;
  vmcs_sws_s s, next_s;
  // A source is left only in its low phase, so no high pulse is ever cut short.
  always_comb begin
    next_s = s;
    case (s.state)
      VMCS_ON_A: begin
        next_s.out = clk_a;
        if (sel && !clk_a) begin
          next_s.state = VMCS_HOLD;
          next_s.out = 1'b0;
        end
      end
      VMCS_ON_B: begin
        next_s.out = clk_b;
        if (!sel && !clk_b) begin
          next_s.state = VMCS_HOLD;
          next_s.out = 1'b0;
        end
      end
      VMCS_HOLD: begin
        next_s.out = 1'b0;
        if (sel ? !clk_b : !clk_a) begin
          next_s.state = sel ? VMCS_ON_B : VMCS_ON_A;
        end
      end
      default: begin
        next_s.state = VMCS_HOLD;
        next_s.out = 1'b0;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '{state: VMCS_ON_A, out: 1'b0};
    end else begin
      s <= next_s;
    end
  end
  assign clk_out = s.out;
  assign on_b = (s.state == VMCS_ON_B);
  a_hold_low_gap: assert property (@(posedge pclk) disable iff (!presetn) // RL14
    s.state == VMCS_HOLD |-> !clk_out ##1 !clk_out)
    else $error("switch output not low around hold");
  a_rise_from_source: assert property (@(posedge pclk) disable iff (!presetn) // RL14
    $rose(clk_out) |-> $past(s.state) != VMCS_HOLD && $past(clk_out) == 1'b0)
    else $error("switch output rose out of hold");
endmodule : vmcs_clk_switch

// ---- tb/vmcs_partner.sv ----
// Stand-in for the reference oscillators and for the consumers counting clock edges.
`timescale 1ns/1ps
module vmcs_partner (
  input  wire logic        pclk,      // System clock.
  input  wire logic        clear,     // Restart the edge counts.
  input  wire logic [11:0] watched,   // Consumer clocks being counted.
  output logic             ref_clk,   // Base reference level.
  output logic             pal_clk,   // PAL reference level.
  output logic [15:0]      rises [12] // Rising edges since the last clear.
);
  // Both references are scaled stand-ins: 14 and 11 system cycles per period.
  logic [3:0]  ref_cnt = 4'h0;
  logic [3:0]  pal_cnt = 4'h0;
  logic [11:0] last    = 12'h000;
  assign ref_clk = ref_cnt < 4'h7;
  assign pal_clk = pal_cnt < 4'h6;
  always @(posedge pclk) begin
    ref_cnt <= (ref_cnt == 4'hd) ? 4'h0 : ref_cnt + 4'h1;
    pal_cnt <= (pal_cnt == 4'ha) ? 4'h0 : pal_cnt + 4'h1;
    last    <= watched;
    for (int i = 0; i < 12; i++) begin
      rises[i] <= clear ? 16'h0000 : rises[i] + {15'h0000, watched[i] & ~last[i]};
    end
  end
endmodule : vmcs_partner

// ---- tb/testbench.sv ----
// Self-checking bench for the clock synthesis block.
`timescale 1ns/1ps
module testbench;
  import vmcs_pkg::*;
  localparam int WIN = 64;
  localparam int MSEL [7] = '{0, 0, 1, 1, 6, 2, 3};
  localparam int MCS  [7] = '{0, 1, 0, 1, 0, 0, 0};
  localparam int MNUM [7] = '{51, 91, 44, 57, 1, 83, 110};
  localparam int MDEN [7] = '{29, 23, 20, 23, 1, 24, 20};
  localparam int MPS  [7] = '{0, 1, 0, 0, 0, 0, 0};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        clear = 1'b1;
  logic        ref_clk;
  logic        pal_clk;
  logic [15:0] rises [12];
  wire  [11:0] clks;
  logic        dual_refresh;
  int          n_errors = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [31:0] rd;
  logic        err;

  always #2.5 pclk = ~pclk;

  vmcs_top u_vmcs_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ref_clock_in(ref_clk), .pal_reference_input(pal_clk),
    .memory_clock(clks[0]), .primary_pixel_clock(clks[1]), .secondary_pixel_clock(clks[2]),
    .panel_refresh_clock(clks[3]), .crt_pixel_clock(clks[4]), .write_fifo_clock(clks[5]),
    .read_fifo_clock(clks[6]), .memory_array_clock(clks[7]), .capture_clock(clks[8]),
    .drawing_engine_clock(clks[9]), .video_processor_clock(clks[10]),
    .tv_encoder_clock(clks[11]), .dual_refresh(dual_refresh));

  vmcs_partner u_vmcs_partner (.pclk(pclk), .clear(clear), .watched(clks),
    .ref_clk(ref_clk), .pal_clk(pal_clk), .rises(rises));

  task automatic conclude;
    $display("comparisons %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic check_word(input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check_word

  // Edge counts may differ by the phase at which the window opens and closes.
  task automatic check_rate(input int exp, input logic [15:0] got);
    comparisons++;
    if ($isunknown(got) || int'(got) + 2 < exp || int'(got) > exp + 2) begin
      n_errors++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : check_rate

  task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd,
                     input logic [1:0] lo = 2'b00);
    paddr   <= {2'b00, idx, lo};
    pwrite  <= wr;
    pwdata  <= wd;
    psel    <= 1'b1;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    // Only pready or the bench timeout ends this wait.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic read_chk(input logic [7:0] idx, input logic [31:0] mask,
                          input logic [31:0] exp, input logic exp_err);
    apb(idx, 1'b0, 32'h0);
    check_word(exp, rd & mask);
    check_word({31'h0, exp_err}, {31'h0, err});
  endtask : read_chk

  task automatic rate(input int idx, input int num, input int den, input int ps);
    repeat (40) @(posedge pclk);
    clear <= 1'b1;
    @(posedge pclk);
    clear <= 1'b0;
    repeat (WIN * 14) @(posedge pclk);
    check_rate((WIN * num) / (den * (1 + ps)), rises[idx]);
  endtask : rate

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      conclude();
    end
  end

  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    read_chk(IDX_MEM_NUM, 32'hff, 32'h20, 1'b0);
    read_chk(IDX_MEM_DEN, 32'hff, 32'h08, 1'b0);
    read_chk(IDX_BLOCK_CLK, 32'h1ffff, 32'h3f, 1'b0);
    read_chk(8'h40, 32'hffffffff, 32'h0, 1'b1);
    apb(IDX_MEM_NUM, 1'b0, 32'h0, 2'b01);
    check_word(32'h1, {31'h0, err});
    rate(0, 32, 8, 0);
    rate(5, 32, 8, 0);
    rate(7, 32, 8, 0);
    rate(10, 32, 8, 0);
    rate(11, 1, 1, 0);
    for (int m = 0; m < 7; m++) begin
      apb(IDX_PIX_SEL, 1'b1, 32'(MSEL[m] << 5));
      apb(IDX_MISC_OUT, 1'b1, 32'(MCS[m] << 2));
      rate(1, MNUM[m], MDEN[m], MPS[m]);
    end
    apb(IDX_PIX_SEL, 1'b1, 32'h80);
    apb(IDX_PIX_NUM, 1'b1, 32'h20);
    apb(IDX_PIX_DEN, 1'b1, 32'h10);
    read_chk(IDX_PIX_NUM, 32'hff, 32'h20, 1'b0);
    read_chk(IDX_STATUS, 32'h1, 32'h1, 1'b0);
    rate(1, 32, 16, 0);
    rate(4, 32, 16, 0);
    apb(IDX_PIX_DEN, 1'b1, 32'h90);
    read_chk(IDX_PIX_DEN, 32'hff, 32'h90, 1'b0);
    rate(1, 32, 16, 1);
    apb(IDX_SEC_NUM, 1'b1, 32'h30);
    apb(IDX_SEC_DEN, 1'b1, 32'h10);
    rate(2, 48, 16, 0);
    apb(IDX_PANEL_CFG, 1'b1, 32'h80);
    check_word(32'h1, {31'h0, dual_refresh});
    rate(4, 48, 16, 0);
    rate(3, 32, 16, 1);
    apb(IDX_BLOCK_CLK, 1'b1, 32'h13f3f);
    rate(8, 48, 16, 0);
    rate(9, 48, 16, 0);
    rate(11, 14, 11, 0);
    apb(IDX_BLOCK_CLK, 1'b1, 32'h0);
    rate(6, 0, 1, 0);
    apb(IDX_MEM_NUM, 1'b1, 32'h10);
    rate(0, 16, 8, 0);
    apb(IDX_PIX_NUM, 1'b1, 32'h5b);
    apb(IDX_PIX_DEN, 1'b1, 32'h97);
    rate(1, 91, 23, 1);
    conclude();
  end
endmodule : testbench
